// File: verilog/lrd_params.svh
// constants of the lvds receive deserializer
`ifndef LRD_PARAMS_SVH
`define LRD_PARAMS_SVH

// clock rate of core_clk_i in MHz
`define LRD_CLK_MHZ        125
// word, fifo and delay geometry, lock match count and bypass width
`define LRD_WORD_W         10
`define LRD_CNT_W          4
`define LRD_FIFO_DEPTH     8
`define LRD_FIFO_AW        3
`define LRD_FIFO_CW        4
`define LRD_BUF_DEPTH      2
`define LRD_DLY_W          6
`define LRD_DLY_MAX        6'h3F
`define LRD_LOCK_MATCH     3'h4
`define LRD_BYPASS_W       4'h1
// asynchronous link, clock, control and configuration pins, positions in the sync vector
`define LRD_SI_DATA        0
`define LRD_SI_BCLK        1
`define LRD_SI_WCLK        2
`define LRD_SI_RCLK        3
`define LRD_SI_RDEN        4
`define LRD_SI_RST         5
`define LRD_SI_BUFEN       6
`define LRD_SI_TERM        7
`define LRD_SI_DYNT        8
`define LRD_SI_DLYEN       9
`define LRD_SI_DLYDIR      10
`define LRD_SI_DLYCLR      11
`define LRD_SI_HALF        12
`define LRD_SI_AUTO        13
`define LRD_SI_FIFOEN      14
`define LRD_SI_W           15

`endif

// File: verilog/lrd_pkg.sv
// types of the lvds receive deserializer
package lrd_pkg;
	typedef enum logic [1:0] {
		LRD_IDLE  = 2'h0,
		LRD_TRAIN = 2'h1,
		LRD_LOCK  = 2'h3
	} lrd_apa_t;
endpackage

// File: verilog/lrd_rx.sv
// lvds receive deserializer with phase alignment and read fifo
`timescale 1ns/1ps
`include "lrd_params.svh"

module lrd_rx (
	// clock and reset
	input  wire logic                    core_clk_i,
	input  wire logic                    rst_i,
	// link and clock pins
	input  wire logic                    serial_data_i,
	input  wire logic                    serial_bit_clock_i,
	input  wire logic                    parallel_word_clock_i,
	input  wire logic                    fabric_read_clock_i,
	// fabric control pins
	input  wire logic                    fifo_read_enable_i,
	input  wire logic                    rx_reset_i,
	input  wire logic                    input_buffer_enable_i,
	input  wire logic                    termination_control_i,
	input  wire logic                    dynamic_termination_i,
	input  wire logic                    delay_adjust_enable_i,
	input  wire logic                    delay_step_direction_i,
	input  wire logic                    delay_counter_clear_i,
	// configuration pins
	input  wire logic [`LRD_CNT_W-1:0]   deser_width_i,
	input  wire logic                    half_rate_i,
	input  wire logic                    auto_phase_alignment_i,
	input  wire logic                    fifo_enable_i,
	// outputs
	output logic      [`LRD_WORD_W-1:0]  data_o,
	output logic                         lock_o,
	output logic                         fifo_empty_o,
	output logic                         overflow_o,
	output logic                         bypass_alternate_out_o,
	output logic                         input_buffer_on_o,
	output logic                         termination_on_o,
	output logic      [`LRD_DLY_W-1:0]   delay_count_o
);

	function automatic logic [`LRD_DLY_W-1:0] lrd_target(input logic [`LRD_DLY_W-1:0] off,
		input logic [`LRD_DLY_W-1:0] per);
		logic [`LRD_DLY_W:0] t;
		t = {1'b0, off} + {2'h0, per[`LRD_DLY_W-1:1]};
		if (t >= {1'b0, per})
			t = t - {1'b0, per};
		return t[`LRD_DLY_W-1:0];
	endfunction

	function automatic logic [`LRD_DLY_W-1:0] lrd_step(input logic [`LRD_DLY_W-1:0] v,
		input logic up);
		if (up)
			return (v == `LRD_DLY_MAX) ? v : v + 6'h01;
		return (v == 6'h00) ? v : v - 6'h01;
	endfunction

	// two-flop synchronisers
	logic [`LRD_SI_W-1:0]   s1_r, s2_r, pin_w;
	logic [`LRD_CNT_W-1:0]  w1_r, w2_r;

	assign pin_w = {fifo_enable_i, auto_phase_alignment_i, half_rate_i,
		delay_counter_clear_i, delay_step_direction_i, delay_adjust_enable_i,
		dynamic_termination_i, termination_control_i, input_buffer_enable_i,
		rx_reset_i, fifo_read_enable_i, fabric_read_clock_i,
		parallel_word_clock_i, serial_bit_clock_i, serial_data_i};

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			s1_r <= '0;
			s2_r <= '0;
			w1_r <= 4'h0;
			w2_r <= 4'h0;
		end else begin
			s1_r <= pin_w;
			s2_r <= s1_r;
			w1_r <= deser_width_i;
			w2_r <= w1_r;
		end
	end

	// decoded events
	logic bclk_q_r, wclk_q_r, rclk_q_r, data_q_r;
	logic rst_any, half, apa_on, bit_in, sample_evt, wclk_rise, rclk_rise;

	assign rst_any    = rst_i | s2_r[`LRD_SI_RST];
	assign half       = s2_r[`LRD_SI_HALF];
	assign apa_on     = s2_r[`LRD_SI_AUTO] & ~half;
	assign bit_in     = s2_r[`LRD_SI_DATA] & s2_r[`LRD_SI_BUFEN];
	// rising edge, both edges in half rate
	assign sample_evt = (s2_r[`LRD_SI_BCLK] & ~bclk_q_r)
		| (half & ~s2_r[`LRD_SI_BCLK] & bclk_q_r);
	assign wclk_rise  = s2_r[`LRD_SI_WCLK] & ~wclk_q_r;
	assign rclk_rise  = s2_r[`LRD_SI_RCLK] & ~rclk_q_r;

	// datapath state
	logic [`LRD_WORD_W-1:0] sh_r, sh_nxt, done_r, done_nxt, data_nxt;
	logic [`LRD_CNT_W-1:0]  cnt_r, cnt_nxt;
	logic [`LRD_DLY_W-1:0]  dly_r, dly_nxt, dcnt_r, dcnt_nxt;
	logic [`LRD_DLY_W-1:0]  per_r, per_nxt, pcnt_r, pcnt_nxt, off_r, off_nxt, tgt_r, tgt_nxt;
	logic [2:0]             match_r, match_nxt;
	logic                   pend_r, pend_nxt, take, push;
	lrd_pkg::lrd_apa_t      st_r, st_nxt;

	always_comb begin
		sh_nxt    = sh_r;
		done_nxt  = done_r;
		cnt_nxt   = cnt_r;
		dly_nxt   = dly_r;
		dcnt_nxt  = dcnt_r;
		pend_nxt  = pend_r;
		per_nxt   = per_r;
		pcnt_nxt  = (pcnt_r == `LRD_DLY_MAX) ? pcnt_r : pcnt_r + 6'h01;
		off_nxt   = off_r;
		tgt_nxt   = tgt_r;
		match_nxt = match_r;
		st_nxt    = st_r;
		take      = 1'b0;
		// delay chain: sample dly_r cycles after the clock edge
		if (sample_evt && dly_r == 6'h00) begin
			take = 1'b1;
		end else if (sample_evt) begin
			pend_nxt = 1'b1;
			dcnt_nxt = dly_r;
		end else if (pend_r && dcnt_r <= 6'h01) begin
			take     = 1'b1;
			pend_nxt = 1'b0;
		end else if (pend_r) begin
			dcnt_nxt = dcnt_r - 6'h01;
		end
		if (take && cnt_r < 4'(`LRD_WORD_W)) begin
			sh_nxt[cnt_r] = bit_in;
			cnt_nxt       = cnt_r + 4'h1;
			if (cnt_r + 4'h1 >= w2_r) begin
				done_nxt = sh_nxt;
				cnt_nxt  = 4'h0;
				sh_nxt   = '0;
			end
		end else if (take) begin
			cnt_nxt = 4'h0;
		end
		// measure transition offset and bit period
		if (s2_r[`LRD_SI_DATA] != data_q_r)
			off_nxt = pcnt_r;
		if (s2_r[`LRD_SI_BCLK] && !bclk_q_r) begin
			per_nxt  = pcnt_r;
			pcnt_nxt = 6'h01;
		end
		if (st_r == lrd_pkg::LRD_TRAIN && s2_r[`LRD_SI_BCLK] && !bclk_q_r) begin
			tgt_nxt   = lrd_target(off_r, pcnt_r);
			match_nxt = (tgt_nxt == tgt_r) ? match_r + 3'h1 : 3'h0;
			if (match_nxt == `LRD_LOCK_MATCH) begin
				dly_nxt = tgt_nxt;
				st_nxt  = lrd_pkg::LRD_LOCK;
			end
		end
		if (!apa_on)
			st_nxt = lrd_pkg::LRD_IDLE;
		// controls act on the word clock edge
		if (wclk_rise && s2_r[`LRD_SI_DLYCLR]) begin
			match_nxt = 3'h0;
			if (apa_on)
				st_nxt = lrd_pkg::LRD_TRAIN;
			else
				dly_nxt = 6'h00;
		end else if (wclk_rise && s2_r[`LRD_SI_DLYEN]) begin
			if (apa_on && st_r == lrd_pkg::LRD_IDLE)
				st_nxt = lrd_pkg::LRD_TRAIN;
			// manual step, ignored under auto alignment
			else if (!apa_on)
				dly_nxt = lrd_step(dly_r, s2_r[`LRD_SI_DLYDIR]);
		end
	end

	// 2-entry buffer and fifo
	logic [`LRD_WORD_W-1:0]  bq_r [`LRD_BUF_DEPTH];
	logic [`LRD_WORD_W-1:0]  mem_r [`LRD_FIFO_DEPTH];
	logic [1:0]              bc_r, bc_nxt;
	logic                    bw_r, bw_nxt, br_r, br_nxt, b_in_rdy, b_out_vld, b_pop;
	logic [`LRD_FIFO_AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [`LRD_FIFO_CW-1:0] fc_r, fc_nxt;
	logic                    f_rd, ovf_nxt;

	always_comb begin
		b_in_rdy  = (bc_r != 2'(`LRD_BUF_DEPTH));
		b_out_vld = (bc_r != 2'h0);
		b_pop     = b_out_vld && (fc_r != 4'(`LRD_FIFO_DEPTH));
		// word handed over on word clock rise
		push      = wclk_rise && s2_r[`LRD_SI_FIFOEN];
		// read only when a word is held
		f_rd      = rclk_rise && s2_r[`LRD_SI_RDEN] && (fc_r != 4'h0) && s2_r[`LRD_SI_FIFOEN];
		bc_nxt    = bc_r + {1'b0, push && b_in_rdy} - {1'b0, b_pop};
		bw_nxt    = bw_r ^ (push && b_in_rdy);
		br_nxt    = br_r ^ b_pop;
		wp_nxt    = wp_r + {2'h0, b_pop};
		rp_nxt    = rp_r + {2'h0, f_rd};
		fc_nxt    = fc_r + {3'h0, b_pop} - {3'h0, f_rd};
		ovf_nxt   = overflow_o | (push && !b_in_rdy);
		data_nxt  = data_o;
		// output word, direct or through the fifo
		if (f_rd)
			data_nxt = mem_r[rp_r];
		else if (wclk_rise && !s2_r[`LRD_SI_FIFOEN])
			data_nxt = done_r;
	end

	always_ff @(posedge core_clk_i) begin
		bclk_q_r <= s2_r[`LRD_SI_BCLK];
		wclk_q_r <= s2_r[`LRD_SI_WCLK];
		rclk_q_r <= s2_r[`LRD_SI_RCLK];
		data_q_r <= s2_r[`LRD_SI_DATA];
		if (push && b_in_rdy)
			bq_r[bw_r] <= done_r;
		if (b_pop)
			mem_r[wp_r] <= bq_r[br_r];
		if (rst_any) begin
			sh_r  <= '0;
			done_r <= '0;
			cnt_r <= 4'h0;
			dly_r <= 6'h00;
			dcnt_r <= 6'h00;
			pend_r <= 1'b0;
			per_r <= 6'h00;
			pcnt_r <= 6'h00;
			off_r <= 6'h00;
			tgt_r <= 6'h00;
			match_r <= 3'h0;
			st_r  <= lrd_pkg::LRD_IDLE;
			bc_r  <= 2'h0;
			bw_r  <= 1'b0;
			br_r  <= 1'b0;
			wp_r  <= 3'h0;
			rp_r  <= 3'h0;
			fc_r  <= 4'h0;
			data_o <= '0;
			lock_o <= 1'b0;
			fifo_empty_o <= 1'b1;
			overflow_o <= 1'b0;
			bypass_alternate_out_o <= 1'b0;
			input_buffer_on_o <= 1'b0;
			termination_on_o <= 1'b0;
			delay_count_o <= 6'h00;
		end else begin
			sh_r  <= sh_nxt;
			done_r <= done_nxt;
			cnt_r <= cnt_nxt;
			dly_r <= dly_nxt;
			dcnt_r <= dcnt_nxt;
			pend_r <= pend_nxt;
			per_r <= per_nxt;
			pcnt_r <= pcnt_nxt;
			off_r <= off_nxt;
			tgt_r <= tgt_nxt;
			match_r <= match_nxt;
			st_r  <= st_nxt;
			bc_r  <= bc_nxt;
			bw_r  <= bw_nxt;
			br_r  <= br_nxt;
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			fc_r  <= fc_nxt;
			data_o <= data_nxt;
			lock_o <= (st_nxt == lrd_pkg::LRD_LOCK);
			fifo_empty_o <= (fc_nxt == 4'h0);
			overflow_o <= ovf_nxt;
			// alternate path only at width one
			bypass_alternate_out_o <= (w2_r == `LRD_BYPASS_W) & bit_in;
			input_buffer_on_o <= s2_r[`LRD_SI_BUFEN];
			termination_on_o <= s2_r[`LRD_SI_DYNT] & s2_r[`LRD_SI_TERM];
			delay_count_o <= dly_nxt;
		end
	end

endmodule

// File: sim/lrd_rx_monitor.sv
// assertions on the deserializer ports
`timescale 1ns/1ps
module lrd_rx_monitor (
	// clock and reset
	input logic       core_clk_i,
	input logic       rst_i,
	input logic       rx_reset_i,
	// controls
	input logic       input_buffer_enable_i,
	input logic       termination_control_i,
	input logic       dynamic_termination_i,
	input logic [3:0] deser_width_i,
	input logic       half_rate_i,
	input logic       auto_phase_alignment_i,
	// outputs
	input logic [9:0] data_o,
	input logic       lock_o,
	input logic       fifo_empty_o,
	input logic       overflow_o,
	input logic       bypass_alternate_out_o,
	input logic       input_buffer_on_o,
	input logic       termination_on_o,
	input logic [5:0] delay_count_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	reset_clears_a: assert property ($fell(rst_i) |-> fifo_empty_o && !lock_o
		&& !overflow_o && data_o == 10'h000 && delay_count_o == 6'h00)
		else $error("outputs not cleared by reset");
	half_unlocked_a: assert property (half_rate_i [*6] |=> !lock_o)
		else $error("lock held in half rate");
	bypass_only_a: assert property (bypass_alternate_out_o |-> $past(deser_width_i, 3) == 4'h1)
		else $error("alternate out outside bypass");
	buffer_on_a: assert property ((input_buffer_enable_i && !rx_reset_i) [*4]
		|-> input_buffer_on_o) else $error("receiver not on");
	term_on_a: assert property ((termination_control_i && dynamic_termination_i
		&& !rx_reset_i) [*4] |-> termination_on_o) else $error("termination not on");
	term_off_a: assert property (!termination_control_i [*4] |-> !termination_on_o)
		else $error("termination not off");
	delay_step_a: assert property (!auto_phase_alignment_i [*5] ##0 $changed(delay_count_o)
		|-> delay_count_o == 6'h00 || (delay_count_o - $past(delay_count_o)) inside {6'h01, 6'h3F})
		else $error("delay moved by more than one step");
	overflow_keep_a: assert property (!rx_reset_i [*4] ##0 overflow_o |=> overflow_o)
		else $error("overflow dropped without reset");
	lock_c: cover property ($rose(lock_o));
	ovf_c: cover property ($rose(overflow_o));
	bypass_c: cover property (bypass_alternate_out_o);
endmodule
bind lrd_rx lrd_rx_monitor u_lrd_rx_monitor (.core_clk_i, .rst_i, .rx_reset_i,
	.input_buffer_enable_i, .termination_control_i, .dynamic_termination_i, .deser_width_i,
	.half_rate_i, .auto_phase_alignment_i, .data_o, .lock_o, .fifo_empty_o, .overflow_o,
	.bypass_alternate_out_o, .input_buffer_on_o, .termination_on_o, .delay_count_o);

// File: sim/lrd_src.sv
// serial source model for bit clock, word clock and data
`timescale 1ns/1ps
module lrd_src (
	// clock
	input  wire logic core_clk_i,
	// link pins
	output logic      bclk_o,
	output logic      sdata_o,
	output logic      wclk_o
);
	initial begin
		bclk_o = 1'b0;
		sdata_o = 1'b0;
		wclk_o = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask
	// one word clock rise per word
	task automatic wpulse;
		wclk_o <= 1'b1;
		tick(4);
		wclk_o <= 1'b0;
		tick(4);
	endtask
	task automatic send(input logic [9:0] w, input int n, input logic half);
		for (int i = 0; i < n; i++) begin
			sdata_o <= w[i];
			tick(4);
			bclk_o <= half ? ~bclk_o : 1'b1;
			tick(4);
			if (!half) bclk_o <= 1'b0;
		end
		sdata_o <= ~w[n-1];
		wpulse();
	endtask
endmodule

// File: sim/test_lrd_rx.sv
// testbench of the lvds receive deserializer
`timescale 1ns/1ps
module test_lrd_rx;
	logic       core_clk_i, rst_i, serial_data_i, serial_bit_clock_i, parallel_word_clock_i;
	logic       fabric_read_clock_i, fifo_read_enable_i, rx_reset_i, input_buffer_enable_i;
	logic       termination_control_i, dynamic_termination_i, delay_adjust_enable_i;
	logic       delay_step_direction_i, delay_counter_clear_i, half_rate_i;
	logic       auto_phase_alignment_i, fifo_enable_i;
	logic [3:0] deser_width_i;
	logic [9:0] data_o;
	logic [5:0] delay_count_o;
	logic       lock_o, fifo_empty_o, overflow_o, bypass_alternate_out_o;
	logic       input_buffer_on_o, termination_on_o;
	int         fails = 0;
	int         checks = 0;
	always #4 core_clk_i = ~core_clk_i;
	lrd_src u_lrd_src (.core_clk_i, .bclk_o(serial_bit_clock_i), .sdata_o(serial_data_i),
		.wclk_o(parallel_word_clock_i));
	lrd_rx u_lrd_rx (.core_clk_i, .rst_i, .serial_data_i, .serial_bit_clock_i,
		.parallel_word_clock_i, .fabric_read_clock_i, .fifo_read_enable_i, .rx_reset_i,
		.input_buffer_enable_i, .termination_control_i, .dynamic_termination_i,
		.delay_adjust_enable_i, .delay_step_direction_i, .delay_counter_clear_i,
		.deser_width_i, .half_rate_i, .auto_phase_alignment_i, .fifo_enable_i, .data_o,
		.lock_o, .fifo_empty_o, .overflow_o, .bypass_alternate_out_o, .input_buffer_on_o,
		.termination_on_o, .delay_count_o);
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask
	task automatic end_sim;
		$display("fails %0d checks %0d", fails, checks);
		if (fails == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic t_reset;
		chk({1'b0, fifo_empty_o, lock_o, overflow_o, delay_count_o}, 10'h100);
		chk(data_o, 10'h000);
	endtask
	task automatic t_ctrl;
		for (int i = 0; i < 8; i++) begin
			{input_buffer_enable_i, termination_control_i, dynamic_termination_i} <= i[2:0];
			tick(4);
			chk({8'h00, input_buffer_on_o, termination_on_o}, {8'h00, i[2], i[1] & i[0]});
		end
		{input_buffer_enable_i, termination_control_i, dynamic_termination_i} <= 3'h7;
		tick(4);
	endtask
	task automatic t_word;
		u_lrd_src.send(10'h2B5, 10, 1'b0);
		chk(data_o, 10'h2B5);
		chk({9'h000, bypass_alternate_out_o}, 10'h000);
		deser_width_i <= 4'h1;
		tick(4);
		fork
			u_lrd_src.send(10'h001, 1, 1'b0);
			begin
				tick(6);
				chk({9'h000, bypass_alternate_out_o}, 10'h001);
			end
		join
		chk({9'h000, data_o[0]}, 10'h001);
		deser_width_i <= 4'h4;
		tick(4);
		u_lrd_src.send(10'h00A, 4, 1'b0);
		chk({6'h00, data_o[3:0]}, 10'h00A);
	endtask
	task automatic t_half;
		half_rate_i <= 1'b1;
		deser_width_i <= 4'h8;
		tick(4);
		u_lrd_src.send(10'h0C3, 8, 1'b1);
		chk({2'h0, data_o[7:0]}, 10'h0C3);
		half_rate_i <= 1'b0;
		deser_width_i <= 4'hA;
		tick(4);
	endtask
	task automatic t_delay;
		delay_adjust_enable_i <= 1'b1;
		delay_step_direction_i <= 1'b1;
		repeat (2) u_lrd_src.wpulse();
		delay_step_direction_i <= 1'b0;
		u_lrd_src.wpulse();
		chk({4'h0, delay_count_o}, 10'h001);
		u_lrd_src.send(10'h2B5, 10, 1'b0);
		chk(data_o, 10'h2B5);
		repeat (2) u_lrd_src.wpulse();
		chk({4'h0, delay_count_o}, 10'h000);
		delay_step_direction_i <= 1'b1;
		u_lrd_src.wpulse();
		delay_counter_clear_i <= 1'b1;
		u_lrd_src.wpulse();
		delay_counter_clear_i <= 1'b0;
		delay_adjust_enable_i <= 1'b0;
		chk({4'h0, delay_count_o}, 10'h000);
	endtask
	task automatic t_align;
		auto_phase_alignment_i <= 1'b1;
		delay_adjust_enable_i <= 1'b1;
		u_lrd_src.wpulse();
		delay_adjust_enable_i <= 1'b0;
		repeat (3) u_lrd_src.send(10'h155, 10, 1'b0);
		chk({9'h000, lock_o}, 10'h001);
		u_lrd_src.send(10'h2B5, 10, 1'b0);
		chk(data_o, 10'h2B5);
		half_rate_i <= 1'b1;
		tick(8);
		chk({9'h000, lock_o}, 10'h000);
		half_rate_i <= 1'b0;
		auto_phase_alignment_i <= 1'b0;
		tick(4);
	endtask
	task automatic rd;
		fifo_read_enable_i <= 1'b1;
		fabric_read_clock_i <= 1'b1;
		tick(4);
		fifo_read_enable_i <= 1'b0;
		fabric_read_clock_i <= 1'b0;
		tick(4);
	endtask
	task automatic t_fifo;
		fifo_enable_i <= 1'b1;
		deser_width_i <= 4'h2;
		tick(4);
		for (int i = 0; i < 11; i++) u_lrd_src.send({8'h00, i[1:0]}, 2, 1'b0);
		chk({8'h00, fifo_empty_o, overflow_o}, 10'h001);
		for (int i = 0; i < 10; i++) begin
			rd();
			chk({8'h00, data_o[1:0]}, {8'h00, i[1:0]});
		end
		chk({9'h000, fifo_empty_o}, 10'h001);
		rd();
		chk({8'h00, fifo_empty_o, data_o[1]}, 10'h002);
		rx_reset_i <= 1'b1;
		tick(4);
		rx_reset_i <= 1'b0;
		tick(4);
		chk({8'h00, fifo_empty_o, overflow_o}, 10'h002);
	endtask
	initial begin
		#60us;
		fails++;
		end_sim();
	end
	initial begin
		{core_clk_i, rx_reset_i, fabric_read_clock_i, fifo_read_enable_i} = 4'h0;
		{termination_control_i, delay_adjust_enable_i, delay_step_direction_i} = 3'h0;
		{delay_counter_clear_i, half_rate_i, auto_phase_alignment_i, fifo_enable_i} = 4'h0;
		{rst_i, input_buffer_enable_i, dynamic_termination_i} = 3'h7;
		deser_width_i = 4'hA;
		repeat (3) @(posedge core_clk_i);
		rst_i <= 1'b0;
		tick(4);
		t_reset();
		t_ctrl();
		t_word();
		t_half();
		t_delay();
		t_align();
		t_fifo();
		end_sim();
	end
endmodule
